// ==== logic/decode_pkg.sv ====
// Shared constants, enumerations and carriers for the instruction decoder.
package decode_pkg;

    localparam int INSTR_WIDTH = 14;
    localparam int DATA_WIDTH = 8;
    localparam int FILE_ADDR_WIDTH = 7;
    localparam int LITERAL_WIDTH = 11;
    localparam int PTR_WIDTH = 16;
    localparam int OFFSET_WIDTH = 6;

    // Oscillator clocks in one instruction cycle and the phase in each of them.
    localparam int INSTR_CLOCKS = 4;
    localparam logic [1:0] Q_DECODE = 2'h0;
    localparam logic [1:0] Q_READ = 2'h1;
    localparam logic [1:0] Q_MODIFY = 2'h2;
    localparam logic [1:0] Q_WRITE = 2'h3;
    localparam logic [1:0] PHASE_RESET = 2'h0;

    // Pointer values with this bit set address program memory.
    localparam int PROG_SPACE_BIT = 15;
    localparam int MODE_DEC_BIT = 0;
    localparam int MODE_POST_BIT = 1;

    localparam logic DEST_ACC = 1'b0;
    localparam logic DEST_FILE = 1'b1;
    localparam logic [5:0] INDIRECT_ADDR_HIGH = 6'h00;
    localparam logic [3:0] ALU_CLEAR = 4'h1;

    typedef enum logic [1:0] {
        CAT_BYTE = 2'h0,
        CAT_BIT = 2'h1,
        CAT_LITERAL_CONTROL = 2'h2
    } category_e;

    typedef enum logic [4:0] {
        OP_NOP = 5'h00,
        OP_BYTE = 5'h01,
        OP_DECREMENT_SKIP_IF_ZERO = 5'h02,
        OP_INCREMENT_SKIP_IF_ZERO = 5'h03,
        OP_BIT_CLEAR = 5'h04,
        OP_BIT_SET = 5'h05,
        OP_BIT_TEST_SKIP_IF_ZERO = 5'h06,
        OP_BIT_TEST_SKIP_IF_ONE = 5'h07,
        OP_CALL_SUBROUTINE = 5'h08,
        OP_JUMP_TO_SUBROUTINE_VIA_ACCUMULATOR = 5'h09,
        OP_ABSOLUTE_JUMP = 5'h0a,
        OP_RELATIVE_JUMP = 5'h0b,
        OP_ACCUMULATOR_RELATIVE_JUMP = 5'h0c,
        OP_RETURN = 5'h0d,
        OP_RETURN_WITH_LITERAL = 5'h0e,
        OP_RETURN_FROM_INTERRUPT = 5'h0f,
        OP_LITERAL = 5'h10,
        OP_SELECT_BANK = 5'h11,
        OP_SELECT_PAGE = 5'h12,
        OP_ADD_POINTER = 5'h13,
        OP_LOAD_INDIRECT = 5'h14,
        OP_STORE_INDIRECT = 5'h15,
        OP_OTHER = 5'h16
    } op_e;

    typedef enum logic [2:0] {
        PC_INCREMENT = 3'h0,
        PC_LOAD_ABSOLUTE = 3'h1,
        PC_ADD_LITERAL = 3'h2,
        PC_ADD_ACCUMULATOR = 3'h3,
        PC_PUSH_LOAD = 3'h4,
        PC_PUSH_ACCUMULATOR = 3'h5,
        PC_POP = 3'h6
    } pc_action_e;

    // Gray codes along execute, extra access, flush.
    typedef enum logic [1:0] {
        ST_EXECUTE = 2'b00,
        ST_EXTRA = 2'b01,
        ST_FLUSH = 2'b11
    } seq_state_e;

    typedef struct packed {
        category_e category;
        op_e op;
        logic [3:0] alu_sel;
        logic [FILE_ADDR_WIDTH-1:0] file_addr;
        logic [2:0] bit_index;
        logic [LITERAL_WIDTH-1:0] literal;
        logic dest;
        logic ptr_sel;
        logic [1:0] pointer_update_mode;
        logic uses_file;
        logic has_result;
        logic indirect;
        logic indexed;
        logic moded;
    } decoded_s;

endpackage

// ==== logic/pointer_update_unit.sv ====
// Address and update arithmetic for one selected indirect pointer.
`timescale 1ns/1ps
`default_nettype none

module pointer_update_unit (
    input wire logic [decode_pkg::PTR_WIDTH-1:0] ptr_value,
    input wire logic [1:0] pointer_update_mode,
    input wire logic moded,
    input wire logic indexed,
    input wire logic [decode_pkg::OFFSET_WIDTH-1:0] offset,
    output logic [decode_pkg::PTR_WIDTH-1:0] access_addr,
    output logic [decode_pkg::PTR_WIDTH-1:0] updated_ptr
);

    localparam logic [decode_pkg::PTR_WIDTH-1:0] PTR_ONE = 16'h0001;
    localparam int EXT_WIDTH = decode_pkg::PTR_WIDTH - decode_pkg::OFFSET_WIDTH;

    logic [decode_pkg::PTR_WIDTH-1:0] step;
    logic [decode_pkg::PTR_WIDTH-1:0] stepped;
    logic [decode_pkg::PTR_WIDTH-1:0] offset_ext;

    always_comb begin
        step = pointer_update_mode[decode_pkg::MODE_DEC_BIT] ? '1 : PTR_ONE;
        stepped = ptr_value + step;
        offset_ext = {{EXT_WIDTH{offset[decode_pkg::OFFSET_WIDTH-1]}}, offset};
        access_addr = ptr_value;
        updated_ptr = ptr_value;
        if (moded) begin
            // Pre modes access the stepped value, post modes the old one.
            updated_ptr = stepped;
            access_addr = pointer_update_mode[decode_pkg::MODE_POST_BIT] ? ptr_value : stepped;
        end else if (indexed) begin
            access_addr = ptr_value + offset_ext;
        end
    end

endmodule

`default_nettype wire

// ==== logic/decode_sequencer.sv ====
// Instruction decoder and four-phase cycle sequencer of the 8-bit core.
`timescale 1ns/1ps
`default_nettype none
////////////////////////////////////////////////////////////////////////////////

module decode_sequencer (
    input wire logic clk,
    input wire logic sys_rst,
    input wire logic [decode_pkg::INSTR_WIDTH-1:0] instr_word,
    input wire logic [decode_pkg::DATA_WIDTH-1:0] read_data,
    input wire logic [decode_pkg::PTR_WIDTH-1:0] ptr0_value,
    input wire logic [decode_pkg::PTR_WIDTH-1:0] ptr1_value,
    output logic [1:0] phase,
    output logic cycle_start,
    output logic fetch_strobe,
    output var decode_pkg::decoded_s decoded,
    output var decode_pkg::pc_action_e pc_action,
    output logic pc_strobe,
    output logic file_read,
    output logic file_write,
    output logic acc_write,
    output logic prog_read,
    output logic ptr_update,
    output logic ptr_update_sel,
    output logic [decode_pkg::PTR_WIDTH-1:0] ptr_next,
    output logic [decode_pkg::PTR_WIDTH-1:0] indirect_addr,
    output logic skip_taken,
    output logic flush_active
);

    decode_pkg::decoded_s next_dec;
    decode_pkg::seq_state_e state;
    decode_pkg::seq_state_e next_state;
    logic file_form;
    logic extra_pending;
    logic next_extra;
    logic next_skip;
    logic two_cycle;
    logic skip_op;
    logic last_data_cycle;
    logic [decode_pkg::PTR_WIDTH-1:0] sel_ptr;
    logic [decode_pkg::PTR_WIDTH-1:0] unit_access;
    logic [decode_pkg::PTR_WIDTH-1:0] unit_updated;

    ////////////////////////////////////////////////////////////////////////////
    // Phase counter: the two-bit count wraps after four clocks.

    always_ff @(posedge clk) begin
        if (sys_rst) begin
            phase <= decode_pkg::PHASE_RESET;
        end else begin
            phase <= phase + 2'h1;
        end
    end

    assign cycle_start = (phase == decode_pkg::Q_DECODE);

    ////////////////////////////////////////////////////////////////////////////
    // Field extraction and opcode decode of the incoming word.

    always_comb begin
        next_dec = '0;
        file_form = 1'b0;
        // Fields are cut from fixed positions of the single word.
        next_dec.file_addr = instr_word[6:0];
        next_dec.bit_index = instr_word[9:7];
        next_dec.literal = instr_word[10:0];
        next_dec.dest = instr_word[7];
        next_dec.ptr_sel = instr_word[2];
        next_dec.pointer_update_mode = instr_word[1:0];
        next_dec.alu_sel = instr_word[11:8];
        next_dec.op = decode_pkg::OP_OTHER;
        next_dec.category = decode_pkg::CAT_LITERAL_CONTROL;
        unique case (instr_word[13:12])
            2'b00: begin
                if (instr_word[11:8] == 4'h0 && !instr_word[7]) begin
                    unique casez (instr_word[6:0])
                        7'b000_1000: next_dec.op = decode_pkg::OP_RETURN;
                        7'b000_1001: next_dec.op = decode_pkg::OP_RETURN_FROM_INTERRUPT;
                        7'b000_1010: begin
                            next_dec.op = decode_pkg::OP_JUMP_TO_SUBROUTINE_VIA_ACCUMULATOR;
                        end
                        7'b000_1011: next_dec.op = decode_pkg::OP_ACCUMULATOR_RELATIVE_JUMP;
                        7'b001_????: begin
                            next_dec.op = instr_word[3] ? decode_pkg::OP_STORE_INDIRECT
                                                        : decode_pkg::OP_LOAD_INDIRECT;
                            next_dec.moded = 1'b1;
                            next_dec.indirect = 1'b1;
                            next_dec.uses_file = 1'b1;
                            next_dec.has_result = 1'b1;
                            next_dec.dest = instr_word[3] ? decode_pkg::DEST_FILE
                                                          : decode_pkg::DEST_ACC;
                        end
                        7'b01?_????: next_dec.op = decode_pkg::OP_SELECT_BANK;
                        7'b000_0000: next_dec.op = decode_pkg::OP_NOP;
                        default: next_dec.op = decode_pkg::OP_OTHER;
                    endcase
                end else begin
                    file_form = 1'b1;
                    if (instr_word[11:8] == 4'hb) begin
                        next_dec.op = decode_pkg::OP_DECREMENT_SKIP_IF_ZERO;
                    end else if (instr_word[11:8] == 4'hf) begin
                        next_dec.op = decode_pkg::OP_INCREMENT_SKIP_IF_ZERO;
                    end else begin
                        next_dec.op = decode_pkg::OP_BYTE;
                    end
                end
            end
            2'b01: begin
                next_dec.category = decode_pkg::CAT_BIT;
                next_dec.uses_file = 1'b1;
                next_dec.dest = decode_pkg::DEST_FILE;
                next_dec.indirect = (instr_word[6:1] == decode_pkg::INDIRECT_ADDR_HIGH);
                next_dec.ptr_sel = instr_word[0];
                unique case (instr_word[11:10])
                    2'b00: next_dec.op = decode_pkg::OP_BIT_CLEAR;
                    2'b01: next_dec.op = decode_pkg::OP_BIT_SET;
                    2'b10: next_dec.op = decode_pkg::OP_BIT_TEST_SKIP_IF_ZERO;
                    2'b11: next_dec.op = decode_pkg::OP_BIT_TEST_SKIP_IF_ONE;
                endcase
                next_dec.has_result = !instr_word[11];
            end
            2'b10: begin
                next_dec.op = instr_word[11] ? decode_pkg::OP_ABSOLUTE_JUMP
                                             : decode_pkg::OP_CALL_SUBROUTINE;
            end
            2'b11: begin
                unique casez (instr_word[11:8])
                    4'b0000, 4'b1000, 4'b1001, 4'b1010, 4'b1100, 4'b1110: begin
                        next_dec.op = decode_pkg::OP_LITERAL;
                        next_dec.has_result = 1'b1;
                        next_dec.dest = decode_pkg::DEST_ACC;
                    end
                    4'b0001: begin
                        next_dec.op = instr_word[7] ? decode_pkg::OP_SELECT_PAGE
                                                    : decode_pkg::OP_ADD_POINTER;
                        next_dec.ptr_sel = instr_word[6];
                    end
                    4'b001?: next_dec.op = decode_pkg::OP_RELATIVE_JUMP;
                    4'b0100: begin
                        next_dec.op = decode_pkg::OP_RETURN_WITH_LITERAL;
                        next_dec.has_result = 1'b1;
                        next_dec.dest = decode_pkg::DEST_ACC;
                    end
                    4'b0101, 4'b0110, 4'b0111, 4'b1011, 4'b1101: begin
                        file_form = 1'b1;
                        next_dec.op = decode_pkg::OP_BYTE;
                    end
                    4'b1111: begin
                        next_dec.op = instr_word[7] ? decode_pkg::OP_STORE_INDIRECT
                                                    : decode_pkg::OP_LOAD_INDIRECT;
                        next_dec.ptr_sel = instr_word[6];
                        next_dec.indexed = 1'b1;
                        next_dec.indirect = 1'b1;
                        next_dec.uses_file = 1'b1;
                        next_dec.has_result = 1'b1;
                        next_dec.dest = instr_word[7] ? decode_pkg::DEST_FILE
                                                      : decode_pkg::DEST_ACC;
                    end
                endcase
            end
        endcase
        if (file_form) begin
            next_dec.category = decode_pkg::CAT_BYTE;
            next_dec.has_result = 1'b1;
            next_dec.dest = instr_word[7];
            next_dec.indirect = (instr_word[6:1] == decode_pkg::INDIRECT_ADDR_HIGH);
            next_dec.ptr_sel = instr_word[0];
            // The clear-accumulator form drops its file address and indirect flag; bit 0 still sets ptr_sel.
            next_dec.uses_file = !(instr_word[11:8] == decode_pkg::ALU_CLEAR
                                   && instr_word[13:12] == 2'b00 && !instr_word[7]);
            if (!next_dec.uses_file) begin
                next_dec.indirect = 1'b0;
                next_dec.file_addr = '0;
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Instruction register: the prefetched word is taken at the decode phase.

    always_ff @(posedge clk) begin
        if (sys_rst) begin
            decoded <= '0;
        end else if (phase == decode_pkg::Q_DECODE) begin
            if (state == decode_pkg::ST_EXECUTE) begin
                decoded <= next_dec;
            end else if (state == decode_pkg::ST_FLUSH) begin
                // A forced no-op keeps the discarded prefetch from acting.
                decoded <= '0;
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Cycle counts per instruction class.

    always_comb begin
        two_cycle = 1'b0;
        skip_op = 1'b0;
        unique case (decoded.op)
            decode_pkg::OP_CALL_SUBROUTINE,
            decode_pkg::OP_JUMP_TO_SUBROUTINE_VIA_ACCUMULATOR: two_cycle = 1'b1;
            decode_pkg::OP_RETURN,
            decode_pkg::OP_RETURN_WITH_LITERAL,
            decode_pkg::OP_RETURN_FROM_INTERRUPT: two_cycle = 1'b1;
            decode_pkg::OP_ABSOLUTE_JUMP,
            decode_pkg::OP_RELATIVE_JUMP,
            decode_pkg::OP_ACCUMULATOR_RELATIVE_JUMP: two_cycle = 1'b1;
            decode_pkg::OP_BIT_TEST_SKIP_IF_ZERO,
            decode_pkg::OP_BIT_TEST_SKIP_IF_ONE,
            decode_pkg::OP_DECREMENT_SKIP_IF_ZERO,
            decode_pkg::OP_INCREMENT_SKIP_IF_ZERO: skip_op = 1'b1;
            default: two_cycle = 1'b0;
        endcase
    end

    always_comb begin
        unique case (decoded.op)
            decode_pkg::OP_CALL_SUBROUTINE: pc_action = decode_pkg::PC_PUSH_LOAD;
            decode_pkg::OP_JUMP_TO_SUBROUTINE_VIA_ACCUMULATOR: begin
                pc_action = decode_pkg::PC_PUSH_ACCUMULATOR;
            end
            decode_pkg::OP_RETURN,
            decode_pkg::OP_RETURN_WITH_LITERAL,
            decode_pkg::OP_RETURN_FROM_INTERRUPT: pc_action = decode_pkg::PC_POP;
            decode_pkg::OP_ABSOLUTE_JUMP: pc_action = decode_pkg::PC_LOAD_ABSOLUTE;
            decode_pkg::OP_RELATIVE_JUMP: pc_action = decode_pkg::PC_ADD_LITERAL;
            decode_pkg::OP_ACCUMULATOR_RELATIVE_JUMP: begin
                pc_action = decode_pkg::PC_ADD_ACCUMULATOR;
            end
            default: pc_action = decode_pkg::PC_INCREMENT;
        endcase
    end

    ////////////////////////////////////////////////////////////////////////////
    // Indirect pointer arithmetic and the program-memory check.

    assign sel_ptr = decoded.ptr_sel ? ptr1_value : ptr0_value;

    pointer_update_unit pointer_unit (
        .ptr_value(sel_ptr),
        .pointer_update_mode(decoded.pointer_update_mode),
        .moded(decoded.moded),
        .indexed(decoded.indexed),
        .offset(decoded.literal[decode_pkg::OFFSET_WIDTH-1:0]),
        .access_addr(unit_access),
        .updated_ptr(unit_updated)
    );

    assign next_extra = decoded.indirect && unit_access[decode_pkg::PROG_SPACE_BIT];

    // Pointers are sampled once, before any update, so the address stays stable.
    always_ff @(posedge clk) begin
        if (sys_rst) begin
            indirect_addr <= '0;
            ptr_next <= '0;
        end else if (state == decode_pkg::ST_EXECUTE && phase == decode_pkg::Q_READ) begin
            indirect_addr <= unit_access;
            ptr_next <= unit_updated;
        end
    end

    always_ff @(posedge clk) begin
        if (sys_rst) begin
            extra_pending <= 1'b0;
        end else if (state == decode_pkg::ST_EXECUTE && phase == decode_pkg::Q_READ) begin
            extra_pending <= next_extra;
        end else if (phase == decode_pkg::Q_WRITE && state != decode_pkg::ST_EXECUTE) begin
            extra_pending <= 1'b0;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Skip decision from the value read in the read phase.

    assign last_data_cycle = (state == decode_pkg::ST_EXECUTE && !extra_pending)
                             || state == decode_pkg::ST_EXTRA;

    always_comb begin
        unique case (decoded.op)
            decode_pkg::OP_BIT_TEST_SKIP_IF_ZERO: next_skip = !read_data[decoded.bit_index];
            decode_pkg::OP_BIT_TEST_SKIP_IF_ONE: next_skip = read_data[decoded.bit_index];
            decode_pkg::OP_DECREMENT_SKIP_IF_ZERO: next_skip = (read_data == 8'h01);
            decode_pkg::OP_INCREMENT_SKIP_IF_ZERO: next_skip = (read_data == 8'hff);
            default: next_skip = 1'b0;
        endcase
    end

    always_ff @(posedge clk) begin
        if (sys_rst) begin
            skip_taken <= 1'b0;
        end else if (phase == decode_pkg::Q_DECODE) begin
            skip_taken <= 1'b0;
        end else if (phase == decode_pkg::Q_MODIFY && last_data_cycle && skip_op) begin
            skip_taken <= next_skip;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Cycle sequencing: execute, optional extra access, optional flush.

    always_comb begin
        next_state = decode_pkg::ST_EXECUTE;
        unique case (state)
            decode_pkg::ST_EXECUTE: begin
                if (extra_pending) begin
                    next_state = decode_pkg::ST_EXTRA;
                end else if (two_cycle || skip_taken) begin
                    next_state = decode_pkg::ST_FLUSH;
                end
            end
            decode_pkg::ST_EXTRA: begin
                if (two_cycle || skip_taken) begin
                    next_state = decode_pkg::ST_FLUSH;
                end
            end
            decode_pkg::ST_FLUSH: next_state = decode_pkg::ST_EXECUTE;
            default: next_state = decode_pkg::ST_EXECUTE;
        endcase
    end

    always_ff @(posedge clk) begin
        if (sys_rst) begin
            state <= decode_pkg::ST_EXECUTE;
        end else if (phase == decode_pkg::Q_WRITE) begin
            state <= next_state;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Strobes toward the register file, program counter and fetch unit.

    // Every file-operand instruction reads first, even pure writes.
    assign file_read = state == decode_pkg::ST_EXECUTE && phase == decode_pkg::Q_READ
                       && decoded.uses_file;
    assign prog_read = state == decode_pkg::ST_EXTRA && phase == decode_pkg::Q_READ;
    assign file_write = last_data_cycle && phase == decode_pkg::Q_WRITE
                        && decoded.has_result
                        && decoded.dest == decode_pkg::DEST_FILE;
    assign acc_write = last_data_cycle && phase == decode_pkg::Q_WRITE
                       && decoded.has_result
                       && decoded.dest == decode_pkg::DEST_ACC;
    assign ptr_update = last_data_cycle && phase == decode_pkg::Q_WRITE
                        && decoded.moded;
    assign ptr_update_sel = decoded.ptr_sel;
    assign pc_strobe = last_data_cycle && phase == decode_pkg::Q_WRITE;
    // The extra access holds the already fetched word, so no new fetch is made.
    assign fetch_strobe = phase == decode_pkg::Q_WRITE && state != decode_pkg::ST_EXTRA;
    assign flush_active = (state == decode_pkg::ST_FLUSH);

endmodule

`default_nettype wire

// ==== tb/mem_model.sv ====
// Behavioural file register store answering the decoder's reads.
`timescale 1ns/1ps
`default_nettype none
module mem_model (
    input wire logic clk,
    input wire logic rd,
    input wire logic [6:0] addr,
    output logic [7:0] read_data
);
    initial read_data = 8'h5a;
    // Outside a read the bus toggles each clock, so stale data comes back unchanged every second clock.
    always @(posedge clk) begin
        read_data <= rd ? {1'b0, addr} : ~read_data;
    end
endmodule
`default_nettype wire

// ==== tb/decode_props.sv ====
// Port timing checks for the decoder.
`timescale 1ns/1ps
`default_nettype none
module decode_props (
    input wire logic clk,
    input wire logic sys_rst,
    input wire logic [1:0] phase,
    input wire logic cycle_start,
    input wire logic fetch_strobe,
    input wire logic pc_strobe,
    input wire logic file_read,
    input wire logic file_write,
    input wire logic acc_write,
    input wire logic prog_read,
    input wire logic skip_taken,
    input wire logic flush_active
);
    default clocking @(posedge clk);
    endclocking
    default disable iff (sys_rst);
    a_phase_steps: assert property (
        !$past(sys_rst) |-> phase == $past(phase) + 2'h1)
    else $error("phase skipped");
    a_start_marks: assert property (cycle_start == (phase == 2'h0))
    else $error("cycle start wrong");
    a_fetch_last: assert property (fetch_strobe |-> phase == 2'h3)
    else $error("fetch off phase");
    a_read_first: assert property (
        file_write |-> $past(file_read, 2) || $past(file_read, 6))
    else $error("write without read");
    a_dest_one: assert property (!(file_write && acc_write))
    else $error("two destinations");
    a_flush_four: assert property (
        $rose(flush_active) |-> phase == 2'h0 ##0 flush_active [*4] ##1 !flush_active)
    else $error("flush length");
    a_flush_quiet: assert property (
        flush_active |-> !(file_read || file_write || acc_write || pc_strobe))
    else $error("flush not quiet");
    a_extra_ends: assert property (prog_read |-> phase == 2'h1 ##2 pc_strobe)
    else $error("extra cycle end");
    // The flag stands through the write phase and the first clock of the flush.
    a_skip_shows: assert property (
        $rose(skip_taken) |-> phase == 2'h3 ##1 flush_active && skip_taken ##1 !skip_taken)
    else $error("skip not flushed");
endmodule
bind decode_sequencer decode_props props (.clk(clk), .sys_rst(sys_rst), .phase(phase),
    .cycle_start(cycle_start), .fetch_strobe(fetch_strobe), .pc_strobe(pc_strobe),
    .file_read(file_read), .file_write(file_write), .acc_write(acc_write),
    .prog_read(prog_read), .skip_taken(skip_taken), .flush_active(flush_active));
`default_nettype wire

// ==== tb/tb_top.sv ====
// Self-checking bench for the instruction decoder.
`timescale 1ns/1ps
`default_nettype none
module tb_top;
    logic clk = 1'b0;
    logic sys_rst = 1'b1;
    logic [13:0] instr_word = 14'h0000;
    logic [15:0] ptr0_value = 16'h8000;
    logic [15:0] ptr1_value = 16'h0000;
    logic [7:0] read_data;
    logic [1:0] phase;
    logic cycle_start, fetch_strobe, pc_strobe, file_read, file_write, acc_write, prog_read;
    logic ptr_update, ptr_update_sel, skip_taken, flush_active;
    logic [15:0] ptr_next, indirect_addr;
    logic [21:0] seen;
    logic [33:0] ptr_seen;
    decode_pkg::decoded_s decoded;
    decode_pkg::pc_action_e pc_action;
    int err_total = 0;
    int comparisons = 0;
    int cyc = 0;
    int seed = 32'he6e0;
    logic [21:0] notes[$];
    // Word, then cycles, extra flag, pc action, file write, acc write, skip.
    localparam logic [22:0] PROG [20] = '{{14'h0060, 9'h080}, {14'h2a55, 9'h108},
        {14'h2123, 9'h120}, {14'h000a, 9'h128}, {14'h0008, 9'h130}, {14'h0009, 9'h130},
        {14'h3477, 9'h132}, {14'h3255, 9'h110}, {14'h000b, 9'h118}, {14'h1803, 9'h080},
        {14'h1903, 9'h101}, {14'h1c03, 9'h101}, {14'h0b81, 9'h105}, {14'h0f01, 9'h082},
        {14'h0010, 9'h142}, {14'h0014, 9'h082}, {14'h3f41, 9'h082}, {14'h3f01, 9'h142},
        {14'h1403, 9'h084}, {14'h3005, 9'h082}};
    decode_sequencer DUT (.clk(clk), .sys_rst(sys_rst), .instr_word(instr_word),
        .read_data(read_data), .ptr0_value(ptr0_value), .ptr1_value(ptr1_value),
        .phase(phase), .cycle_start(cycle_start), .fetch_strobe(fetch_strobe),
        .decoded(decoded), .pc_action(pc_action), .pc_strobe(pc_strobe),
        .file_read(file_read), .file_write(file_write), .acc_write(acc_write),
        .prog_read(prog_read), .ptr_update(ptr_update), .ptr_update_sel(ptr_update_sel),
        .ptr_next(ptr_next), .indirect_addr(indirect_addr), .skip_taken(skip_taken),
        .flush_active(flush_active));
    assign seen = {cyc[15:0], pc_action, file_write, acc_write, skip_taken};
    assign ptr_seen = {ptr_update, ptr_update_sel, indirect_addr, ptr_next};
    mem_model mem (.clk(clk), .rd(file_read | prog_read), .addr(decoded.file_addr),
        .read_data(read_data));
    initial forever #20 clk = ~clk;
    always @(posedge clk) cyc <= cyc + 1;
    ////////////////////////////////////////////////////////////////////////////////
    task automatic tally_and_finish();
        $display("comparisons %0d mismatches %0d", comparisons, err_total);
        if (err_total == 0 && comparisons > 0) begin
            $display("bench passed");
        end else begin
            $display("bench failed");
        end
        $finish;
    endtask
    task automatic compare(input logic [21:0] got, input logic [21:0] exp);
        comparisons++;
        if (got !== exp) begin
            err_total++;
            $display("ERROR %0t expected %h got %h", $time, exp, got);
        end
    endtask
    task automatic compare_ptr(input logic [33:0] got, input logic [33:0] exp);
        comparisons++;
        if (got !== exp) begin
            err_total++;
            $display("ERROR %0t pointer expected %h got %h", $time, exp, got);
        end
    endtask
    // The note fixes the clock of the pc strobe, so a wrong cycle count shows.
    task automatic run(input logic [13:0] w, input logic [8:0] e);
        instr_word <= w;
        notes.push_back({16'(cyc + 4 + 4 * e[6]), e[5:0]});
        repeat (4 * e[8:7]) @(posedge clk);
    endtask
    always @(posedge clk) begin
        if (!sys_rst && pc_strobe === 1'b1 && notes.size() > 0) begin
            compare(seen, notes.pop_front());
        end
    end
    ////////////////////////////////////////////////////////////////////////////////
    initial begin
        logic d;
        logic x;
        logic [1:0] m;
        logic [6:0] a;
        logic [15:0] p;
        logic [15:0] s;
        logic [33:0] w;
        repeat (4) @(posedge clk);
        sys_rst <= 1'b0;
        foreach (PROG[i]) begin
            run(PROG[i][22:9], PROG[i][8:0]);
        end
        $display("table done");
        repeat (6) begin
            d = 1'($random(seed));
            a = 7'($random(seed));
            m = 2'($random(seed));
            // Pointer one stays clear of the top so a step never reaches program space.
            p = (16'($random(seed)) & 16'h3fff) | 16'h0001;
            s = m[0] ? 16'hffff : 16'h0001;
            w = {2'h3, m[1] ? p : p + s, p + s};
            // Address zero goes through pointer zero, which points into program space.
            x = (a == 7'h00);
            ptr1_value <= p;
            run(14'h0700 | {d, a}, {x ? 2'h2 : 2'h1, x, 3'h0, d, !d, 1'b0});
            run(14'h0014 | {d, 1'b0, m}, {2'h1, 4'h0, d, !d, 1'b0});
            compare_ptr(ptr_seen, w);
        end
        $display("random done");
        repeat (8) @(posedge clk);
        compare(22'(notes.size()), 22'h0);
        tally_and_finish();
    end
endmodule
`default_nettype wire
